//--- rfg_ref_gen.sv
`timescale 1ns/1ps
module rfg_ref_gen #(
  parameter longint SINE_TMO = rfg_pkg::SINE_TMO_CYC,
  parameter int DEPTH = rfg_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire rfg_pkg::rfg_mode_type i_ref_mode,
  input wire logic i_ref_pin,
  input wire logic signed [rfg_pkg::SMP_W-1:0] i_ref_smp,
  input wire logic i_ref_smp_valid,
  input wire logic [rfg_pkg::PHASE_W-1:0] i_int_ftw,
  input wire logic signed [rfg_pkg::OFS_W-1:0] i_offset_mdeg,
  input wire logic [rfg_pkg::HARM_W-1:0] i_harm_req,
  input wire logic i_harm_load,
  input wire logic i_sync_en,
  input wire logic signed [rfg_pkg::SMP_W-1:0] i_adc_data,
  input wire logic i_adc_valid,
  output logic o_adc_ready,
  output logic signed [31:0] o_x_prod,
  output logic signed [31:0] o_y_prod,
  output logic o_prod_valid,
  input wire logic i_prod_ready,
  input wire logic signed [31:0] i_x_avg,
  input wire logic signed [31:0] i_y_avg,
  input wire logic i_meas_start,
  output logic [31:0] o_mag_rms,
  output logic signed [rfg_pkg::OFS_W-1:0] o_phase_mdeg,
  output logic o_meas_done,
  output logic signed [rfg_pkg::SMP_W-1:0] o_osc_sine,
  output logic o_sync,
  output logic o_locked,
  output logic [rfg_pkg::HARM_W-1:0] o_harm,
  output logic o_harm_reject
);
  import rfg_pkg::*;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  if (SINE_TMO < longint'(REF_MIN_CYC) || SINE_TMO >= 64'h0_ffff_ffff ||
      DEPTH < 2) begin : g_bad
    $error("timeout or fifo depth out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clamp a signed tuning word into the legal band
  function automatic logic [31:0] f_clamp(input logic signed [40:0] v);
    if (v < 0) begin
      f_clamp = 32'h0;
    end else if (v > $signed({9'h000, FTW_MAX})) begin
      f_clamp = FTW_MAX;
    end else begin
      f_clamp = v[31:0];
    end
  endfunction

  // Parabolic sine of a phase word
  function automatic logic signed [15:0] f_sine(input logic [31:0] p);
    logic [29:0] u;
    logic [29:0] sq;
    logic signed [15:0] mag;
    begin
      u = {15'h0000, p[30:16]};
      sq = 30'(u * (30'h0000_8000 - u));
      mag = $signed(16'(sq >> 14));
      f_sine = p[31] ? -mag : mag;
    end
  endfunction

  // Highest set bit index
  function automatic logic [5:0] f_msb(input logic [31:0] v);
    f_msb = 6'h0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        f_msb = 6'(i);
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reference event detection

  logic ref_meta;
  logic ref_sync;
  logic ref_prev;
  logic signed [SMP_W-1:0] ana_prev;
  logic [31:0] since_evt;
  logic [7:0] wraps;
  logic seen_evt;
  logic [31:0] phase;
  logic [31:0] freq_int;

  // Edge and crossing decode
  wire ttl_rise = ref_sync && !ref_prev;
  wire ttl_fall = !ref_sync && ref_prev;
  wire ana_cross = i_ref_smp_valid && (ana_prev < 0) && (i_ref_smp >= 0);
  wire raw_evt = (i_ref_mode == RFG_EXT_SINE) ? ana_cross :
                 (i_ref_mode == RFG_POS_TTL) ? ttl_rise :
                 (i_ref_mode == RFG_NEG_TTL) ? ttl_fall : 1'b0;
  wire evt_ok = raw_evt && (since_evt >= REF_MIN_CYC - 32'h1);
  wire ext_mode = (i_ref_mode != RFG_INTERNAL);
  wire [31:0] tmo_cyc = 32'(SINE_TMO);
  wire sine_lost = (i_ref_mode == RFG_EXT_SINE) && (since_evt >= tmo_cyc);

  // Pin synchroniser, analog history, event spacing
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
      ana_prev <= '0;
      since_evt <= '0;
    end else begin
      ref_meta <= i_ref_pin;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
      if (i_ref_smp_valid) begin
        ana_prev <= i_ref_smp;
      end
      since_evt <= evt_ok ? 32'h0 : since_evt + 32'(since_evt != '1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator and digital phase lock

  // Internal word clamped, loop word from integrator
  wire [31:0] ftw = ext_mode ? freq_int : f_clamp($signed({9'h000, i_int_ftw}));
  wire [32:0] phase_sum = {1'b0, phase} + {1'b0, ftw};
  wire phase_wrap = phase_sum[32];
  // Accumulated phase since last event, less one turn
  wire signed [40:0] ph_err = $signed({1'b0, wraps, phase}) -
                              41'sh001_0000_0000;
  wire [5:0] gain_sh = f_msb(since_evt) + 6'h1;
  wire [31:0] next_freq = f_clamp($signed({9'h000, freq_int}) -
                                  (ph_err >>> gain_sh));
  wire err_small = (ph_err < $signed({9'h000, LOCK_TOL})) &&
                   (ph_err > -$signed({9'h000, LOCK_TOL}));
  wire ph_hi = phase[31];

  // Accumulator, loop integrator and lock state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= '0;
      freq_int <= '0;
      wraps <= '0;
      seen_evt <= 1'b0;
      o_locked <= 1'b0;
    end else begin
      if (ext_mode && evt_ok) begin
        phase <= 32'h0;
        wraps <= '0;
        seen_evt <= 1'b1;
        if (seen_evt) begin
          freq_int <= next_freq;
        end
        o_locked <= seen_evt && err_small;
      end else begin
        phase <= phase_sum[31:0];
        wraps <= wraps + 8'(phase_wrap && wraps != 8'hff);
        if (!ext_mode) begin
          seen_evt <= 1'b0;
          o_locked <= 1'b1;
        end else if (sine_lost) begin
          o_locked <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Harmonic select and detector references

  logic signed [15:0] x_ref;
  logic signed [15:0] y_ref;

  wire [38:0] harm_prod = 39'(i_harm_req) * 39'(ftw);
  wire harm_ok = (i_harm_req != '0) && (i_harm_req <= HARM_MAX) &&
                 (harm_prod <= 39'(FTW_MAX));
  // Phase arithmetic at 2^-32 turn, about 8e-8 degree
  wire [31:0] det_phase = 32'(phase * 32'(o_harm));
  wire signed [63:0] ofs_full = 64'(i_offset_mdeg) * MDEG_K;
  wire [31:0] ofs_ph = 32'(ofs_full >>> MDEG_FRAC);
  wire [31:0] x_ph = det_phase + ofs_ph;
  wire [31:0] y_ph = x_ph + QUAD_SHIFT;

  // Harmonic register, sine, sync and reference waves
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_harm <= HARM_RST;
      o_harm_reject <= 1'b0;
      o_osc_sine <= '0;
      o_sync <= 1'b0;
      x_ref <= '0;
      y_ref <= '0;
    end else begin
      if (i_harm_load && harm_ok) begin
        o_harm <= i_harm_req;
      end
      o_harm_reject <= i_harm_load && !harm_ok;
      o_osc_sine <= f_sine(phase);
      o_sync <= i_sync_en && !ph_hi;
      x_ref <= f_sine(x_ph);
      y_ref <= f_sine(y_ph);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample buffer and detector multipliers

  rfg_stream_if #(.W(SMP_W)) adc_in();
  rfg_stream_if #(.W(SMP_W)) adc_out();

  // Converter samples, nominally one per ADC_CYC clocks
  assign adc_in.data = i_adc_data;
  assign adc_in.valid = i_adc_valid;
  assign o_adc_ready = adc_in.ready;
  assign adc_out.ready = !o_prod_valid || i_prod_ready;
  wire take = adc_out.valid && adc_out.ready;

  rfg_fifo #(.W(SMP_W), .DEPTH(DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .wr(adc_in),
    .rd(adc_out)
  );

  // Products held until taken downstream
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_x_prod <= '0;
      o_y_prod <= '0;
      o_prod_valid <= 1'b0;
    end else begin
      if (take) begin
        o_x_prod <= $signed(adc_out.data) * x_ref;
        o_y_prod <= $signed(adc_out.data) * y_ref;
      end
      o_prod_valid <= take || (o_prod_valid && !i_prod_ready);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Magnitude and phase of filtered results

  logic crd_done;
  logic [33:0] crd_mag;
  logic signed [31:0] crd_ang;

  rfg_cordic #(.W(32), .ITER(CORDIC_N)) u_cordic (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_start(i_meas_start),
    .i_x(i_x_avg),
    .i_y(i_y_avg),
    .o_done(crd_done),
    .o_mag(crd_mag),
    .o_angle(crd_ang)
  );

  // Gain removal and peak to rms, turns to millidegrees
  wire [50:0] rms_full = 51'(crd_mag) * 51'(RMS_SCALE);
  wire signed [63:0] deg_full = 64'(crd_ang) *
                                $signed({32'h0, MDEG_PER_TURN});

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mag_rms <= '0;
      o_phase_mdeg <= '0;
      o_meas_done <= 1'b0;
    end else begin
      o_meas_done <= crd_done;
      if (crd_done) begin
        o_mag_rms <= 32'(rms_full >> 16);
        o_phase_mdeg <= OFS_W'(deg_full >>> 32);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  harm_range_a: assert property (
    o_harm >= HARM_RST && o_harm <= HARM_MAX)
    else $error("harmonic out of range");
  harm_keep_a: assert property (
    i_harm_load && !harm_ok |=> o_harm == $past(o_harm) && o_harm_reject)
    else $error("refused harmonic changed the multiple");
  int_mode_a: assert property (
    i_ref_mode == RFG_INTERNAL |=> phase == 32'($past(phase) + $past(ftw)))
    else $error("internal mode phase step wrong");
  lock_zero_a: assert property (
    evt_ok && ext_mode |=> phase == 32'h0 ##1 phase == $past(ftw))
    else $error("oscillator not zeroed at event");
  evt_space_a: assert property (
    evt_ok |=> !evt_ok [*8])
    else $error("events closer than minimum period");
  ftw_max_a: assert property (
    ftw <= FTW_MAX)
    else $error("tuning word above limit");
  quad_shift_a: assert property (
    32'(y_ph - x_ph) == QUAD_SHIFT)
    else $error("quadrature shift wrong");
  sync_edge_a: assert property (
    $rose(o_sync) && $past(i_sync_en, 2) && $past(i_arst_n, 2) |->
      $past(ph_hi, 2))
    else $error("sync rose without crossing");
  prod_hold_a: assert property (
    o_prod_valid && !i_prod_ready |=>
      o_prod_valid && $stable(o_x_prod) && $stable(o_y_prod))
    else $error("product changed while stalled");
  sine_lost_a: assert property (
    sine_lost && !evt_ok |=> !o_locked)
    else $error("lock kept without analog crossings");

  evt_lock_c: cover property (evt_ok ##[1:1000] evt_ok ##1 o_locked);
  harm_ref_c: cover property (i_harm_load && !harm_ok);
  meas_c: cover property (i_meas_start ##[1:40] o_meas_done);
endmodule

//--- rfg_pkg.sv
package rfg_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PHASE_W = 32;
  localparam int SMP_W = 16;
  localparam int HARM_W = 7;
  localparam int OFS_W = 20;
  localparam int FIFO_DEPTH = 32;
  localparam int CORDIC_N = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Rates and derived cycle counts
  localparam longint CLK_HZ = 200_000_000;
  localparam longint REF_MAX_HZ = 2_500_000;
  localparam longint SINE_MIN_HZ = 1;
  localparam longint ADC_HZ = 10_000_000;
  // Largest tuning word, rounded down
  localparam logic [31:0] FTW_MAX = 32'((REF_MAX_HZ <<< 32) / CLK_HZ);
  // Least reference period, rounded up
  localparam logic [31:0] REF_MIN_CYC =
    32'((CLK_HZ + REF_MAX_HZ - 1) / REF_MAX_HZ);
  // Longest wait for an analog crossing
  localparam longint SINE_TMO_CYC = CLK_HZ / SINE_MIN_HZ;
  // Sample spacing of the converter stream
  localparam logic [31:0] ADC_CYC = 32'(CLK_HZ / ADC_HZ);

  ////////////////////////////////////////////////////////////////////////////
  // Harmonic, phase and scaling constants
  localparam logic [6:0] HARM_MAX = 7'h63;
  localparam logic [6:0] HARM_RST = 7'h01;
  localparam logic [31:0] QUAD_SHIFT = 32'h4000_0000;
  localparam longint MDEG_K = (longint'(1) <<< 48) / 360000;
  localparam int MDEG_FRAC = 16;
  localparam logic [31:0] MDEG_PER_TURN = 32'h0005_7e40;
  localparam logic [16:0] RMS_SCALE = 17'h0_dbd9;
  localparam logic [31:0] LOCK_TOL = 32'h0100_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and states
  typedef enum logic [1:0] {
    RFG_INTERNAL = 2'b00,
    RFG_EXT_SINE = 2'b01,
    RFG_POS_TTL = 2'b10,
    RFG_NEG_TTL = 2'b11
  } rfg_mode_type;

  typedef enum logic [0:0] {
    RFG_CRD_IDLE = 1'b0,
    RFG_CRD_RUN = 1'b1
  } rfg_crd_state_type;
endpackage

//--- rfg_stream_if.sv
`timescale 1ns/1ps
interface rfg_stream_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

//--- rfg_fifo.sv
`timescale 1ns/1ps
module rfg_fifo #(
  parameter int W = 16,
  parameter int DEPTH = rfg_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  rfg_stream_if.snk wr,
  rfg_stream_if.src rd
);
  import rfg_pkg::*;
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad
    $error("fifo depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] cnt;

  // Handshakes and next fill level
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;
  wire [AW:0] next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  assign rd.valid = (cnt != '0);
  assign rd.data = mem[rptr];

  // Pointers, level and registered ready
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
      wr.ready <= 1'b1;
    end else begin
      wptr <= wptr + AW'(push);
      rptr <= rptr + AW'(pop);
      cnt <= next_cnt;
      wr.ready <= (next_cnt != (AW+1)'(DEPTH));
    end
  end

  // Storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wptr] <= wr.data;
    end
  end

  fifo_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cnt <= (AW+1)'(DEPTH) && (wr.ready == (cnt != (AW+1)'(DEPTH))))
    else $error("fifo level or ready wrong");
  fifo_full_c: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !wr.ready && wr.valid);
endmodule

//--- rfg_cordic.sv
`timescale 1ns/1ps
module rfg_cordic #(
  parameter int W = 32,
  parameter int ITER = rfg_pkg::CORDIC_N
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic signed [W-1:0] i_x,
  input wire logic signed [W-1:0] i_y,
  output logic o_done,
  output logic [W+1:0] o_mag,
  output logic signed [31:0] o_angle
);
  import rfg_pkg::*;

  if (ITER < 1 || ITER > 16 || W < 8) begin : g_bad
    $error("cordic iteration count out of range");
  end

  // Arctangent of 2^-i as a fraction of one turn
  function automatic logic [31:0] f_atan(input logic [3:0] i);
    case (i)
      4'h0: f_atan = 32'h2000_0000;
      4'h1: f_atan = 32'h12e4_051e;
      4'h2: f_atan = 32'h09fb_385b;
      4'h3: f_atan = 32'h0511_11d4;
      4'h4: f_atan = 32'h028b_0d43;
      4'h5: f_atan = 32'h0145_d7e1;
      4'h6: f_atan = 32'h00a2_f61e;
      4'h7: f_atan = 32'h0051_7c55;
      4'h8: f_atan = 32'h0028_be53;
      4'h9: f_atan = 32'h0014_5f2f;
      4'ha: f_atan = 32'h000a_2f98;
      4'hb: f_atan = 32'h0005_17cc;
      4'hc: f_atan = 32'h0002_8be6;
      4'hd: f_atan = 32'h0001_45f3;
      4'he: f_atan = 32'h0000_a2fa;
      default: f_atan = 32'h0000_517d;
    endcase
  endfunction

  rfg_crd_state_type state;
  rfg_crd_state_type next_state;
  logic signed [W+2:0] x;
  logic signed [W+2:0] y;
  logic [31:0] z;
  logic [3:0] it;

  // One vectoring micro-rotation
  wire signed [W+2:0] xs = x >>> it;
  wire signed [W+2:0] ys = y >>> it;
  wire neg_y = (y < 0);
  wire last = (it == 4'(ITER - 1));
  wire signed [W+2:0] next_x = neg_y ? x - ys : x + ys;
  wire signed [W+2:0] next_y = neg_y ? y + xs : y - xs;
  wire [31:0] next_z = neg_y ? z - f_atan(it) : z + f_atan(it);
  wire flip = (i_x < 0);
  wire signed [W+2:0] ext_x = (W+3)'(i_x);
  wire signed [W+2:0] ext_y = (W+3)'(i_y);

  // Sequencer
  always_comb begin
    case (state)
      RFG_CRD_IDLE: next_state = i_start ? RFG_CRD_RUN : RFG_CRD_IDLE;
      RFG_CRD_RUN: next_state = last ? RFG_CRD_IDLE : RFG_CRD_RUN;
      default: next_state = RFG_CRD_IDLE;
    endcase
  end

  // Datapath, left half-plane folded by half a turn
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= RFG_CRD_IDLE;
      x <= '0;
      y <= '0;
      z <= '0;
      it <= '0;
      o_done <= 1'b0;
      o_mag <= '0;
      o_angle <= '0;
    end else begin
      state <= next_state;
      o_done <= (state == RFG_CRD_RUN) && last;
      if (state == RFG_CRD_IDLE && i_start) begin
        x <= flip ? -ext_x : ext_x;
        y <= flip ? -ext_y : ext_y;
        z <= flip ? 32'h8000_0000 : 32'h0;
        it <= '0;
      end else if (state == RFG_CRD_RUN) begin
        x <= next_x;
        y <= next_y;
        z <= next_z;
        it <= it + 4'h1;
        if (last) begin
          o_mag <= (W+2)'(next_x);
          o_angle <= $signed(next_z);
        end
      end
    end
  end
endmodule

//--- rfg_ref_src.sv
`timescale 1ns/1ps
// External reference: logic square wave and a sampled copy of it
module rfg_ref_src (
  input wire logic i_sys_clk,
  input wire logic i_run,
  input wire logic [15:0] i_half,
  output logic o_pin,
  output logic signed [15:0] o_smp,
  output logic o_smp_valid
);
  int cnt;
  // Idle values at time zero
  initial begin
    o_pin = 1'b0;
    o_smp = 16'sh0;
    o_smp_valid = 1'b0;
    cnt = 0;
  end
  // Logic edges every i_half clocks, no rate limit applied
  always @(posedge i_sys_clk) begin
    #1;
    if (i_run) begin
      cnt = cnt + 1;
      if (cnt >= i_half) begin
        cnt = 0;
        o_pin = !o_pin;
      end
      o_smp = o_pin ? 16'sh2000 : -16'sh2000;
      o_smp_valid = 1'b1;
    end else begin
      // Stopped: samples invalid and changing
      cnt = 0;
      o_smp = ~o_smp;
      o_smp_valid = 1'b0;
    end
  end
endmodule

//--- rfg_ref_gen_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  errors++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module rfg_ref_gen_tb;
  import rfg_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  rfg_mode_type mode = RFG_INTERNAL;
  logic run = 1'b0;
  logic pin, smpv, adc_ready, pv, mdone, sync, locked, hrej;
  logic signed [15:0] smp, sine;
  logic signed [15:0] adc_data = 16'sh4000;
  logic [31:0] ftw = 32'h0100_0000;
  logic signed [19:0] ofs = 20'sh0;
  logic [6:0] hreq = 7'h01;
  logic [6:0] harm;
  logic hload = 1'b0;
  logic sync_en = 1'b1;
  logic adc_valid = 1'b0;
  logic pr = 1'b1;
  logic mstart = 1'b0;
  logic signed [31:0] xp, yp;
  logic signed [31:0] xa = 32'sh0;
  logic signed [31:0] ya = 32'sh0;
  logic [31:0] mag;
  logic signed [19:0] ph;
  int errors = 0;
  int comparisons = 0;

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  rfg_ref_src src (.i_sys_clk(clk), .i_run(run), .i_half(16'd100),
    .o_pin(pin), .o_smp(smp), .o_smp_valid(smpv));

  rfg_ref_gen #(.SINE_TMO(400), .DEPTH(FIFO_DEPTH)) dut (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_ref_mode(mode),
    .i_ref_pin(pin), .i_ref_smp(smp), .i_ref_smp_valid(smpv),
    .i_int_ftw(ftw), .i_offset_mdeg(ofs), .i_harm_req(hreq),
    .i_harm_load(hload), .i_sync_en(sync_en), .i_adc_data(adc_data),
    .i_adc_valid(adc_valid), .o_adc_ready(adc_ready), .o_x_prod(xp),
    .o_y_prod(yp), .o_prod_valid(pv), .i_prod_ready(pr),
    .i_x_avg(xa), .i_y_avg(ya), .i_meas_start(mstart),
    .o_mag_rms(mag), .o_phase_mdeg(ph), .o_meas_done(mdone),
    .o_osc_sine(sine), .o_sync(sync), .o_locked(locked),
    .o_harm(harm), .o_harm_reject(hrej));

  ////////////////////
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    cyc(5);
    arst_n = 1'b1;
  endtask

  function automatic logic near(logic signed [31:0] a, b);
    return (a - b <= 32'sh8000) && (b - a <= 32'sh8000);
  endfunction

  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////
  // Scenarios
  task automatic harm_t(input logic [6:0] n, input logic rej,
                        input logic [6:0] e);
    logic r;
    hreq = n;
    hload = 1'b1;
    r = 1'b0;
    repeat (3) begin
      cyc(1);
      hload = 1'b0;
      r = r | (hrej === 1'b1);
    end
    `CHK(r, rej)
    `CHK(harm, e)
  endtask

  task automatic sync_t(input int e);
    int n;
    n = 0;
    repeat (256) begin
      cyc(1);
      n += (sync === 1'b1);
    end
    `CHK(n, e)
  endtask

  // Oscillator sine over one full turn of 256 steps
  task automatic sine_t();
    int pos;
    logic signed [15:0] pk;
    pos = 0;
    pk = 16'sh0;
    repeat (256) begin
      cyc(1);
      pos += (sine > 16'sh0);
      if (sine > pk) begin
        pk = sine;
      end
    end
    `CHK(pos, 127)
    `CHK(pk, 16'sh4000)
  endtask

  task automatic prod_t(input int o, output logic signed [31:0] x, y);
    int k;
    ofs = o[19:0];
    do_reset();
    cyc(37);
    adc_valid = 1'b1;
    cyc(1);
    adc_valid = 1'b0;
    k = 0;
    while (pv !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    x = xp;
    y = yp;
  endtask

  task automatic quad_t();
    logic signed [31:0] x0, y0, x1, y1;
    prod_t(0, x0, y0);
    prod_t(90000, x1, y1);
    `CHK(near(x1, y0), 1'b1)
    prod_t(360000, x1, y1);
    `CHK(near(x1, x0), 1'b1)
    prod_t(-270000, x1, y1);
    `CHK(near(x1, y0), 1'b1)
    `CHK(x0 == 32'sh0, 1'b0)
  endtask

  task automatic fifo_t();
    int acc, got, k;
    logic rdy;
    logic signed [31:0] x0;
    do_reset();
    pr = 1'b0;
    adc_valid = 1'b1;
    acc = 0;
    rdy = adc_ready;
    for (k = 0; k < 40 && rdy === 1'b1; k++) begin
      cyc(1);
      acc++;
      rdy = adc_ready;
    end
    adc_valid = 1'b0;
    x0 = xp;
    cyc(4);
    `CHK(pv, 1'b1)
    `CHK(xp, x0)
    `CHK(acc >= FIFO_DEPTH, 1'b1)
    pr = 1'b1;
    got = 0;
    for (k = 0; k < 100; k++) begin
      got += (pv === 1'b1);
      cyc(1);
    end
    `CHK(got, acc)
    `CHK(adc_ready, 1'b1)
  endtask

  task automatic meas_t(input int x, y, ep);
    int n;
    xa = x;
    ya = y;
    mstart = 1'b1;
    cyc(1);
    mstart = 1'b0;
    n = 1;
    while (mdone !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    `CHK(n, 18)
    `CHK((int'(mag) - 4243) inside {[-45:45]}, 1'b1)
    `CHK((int'(ph) - ep) inside {[-100:100]}, 1'b1)
  endtask

  task automatic lock_t(input rfg_mode_type m);
    do_reset();
    mode = m;
    run = 1'b1;
    cyc(8000);
    if (m == RFG_NEG_TTL) @(negedge pin);
    else @(posedge pin);
    // Pin edges reach the detector two flops later than samples
    if (m != RFG_EXT_SINE) cyc(2);
    `CHK(locked, 1'b1)
    `CHK(sync, 1'b0)
    cyc(1);
    `CHK(sync, 1'b1)
    run = 1'b0;
    cyc(600);
    if (m == RFG_EXT_SINE) `CHK(locked, 1'b0)
    mode = RFG_INTERNAL;
  endtask

  // Hang guard
  initial begin
    #400us;
    errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    do_reset();
    `CHK(harm, HARM_RST)
    harm_t(7'h03, 1'b0, 7'h03);
    harm_t(7'h04, 1'b1, 7'h03);
    harm_t(7'h00, 1'b1, 7'h03);
    harm_t(7'h64, 1'b1, 7'h03);
    sync_t(128);
    sine_t();
    ftw = 32'd500000;
    harm_t(7'h63, 1'b0, 7'h63);
    ftw = 32'h0100_0000;
    sync_t(128);
    sync_en = 1'b0;
    sync_t(0);
    sync_en = 1'b1;
    `CHK(locked, 1'b1)
    quad_t();
    fifo_t();
    meas_t(3000, 0, 0);
    meas_t(0, 3000, 90000);
    meas_t(0, -3000, -90000);
    lock_t(RFG_POS_TTL);
    lock_t(RFG_NEG_TTL);
    lock_t(RFG_EXT_SINE);
    report_and_stop();
  end
endmodule
